// ==== design/rcfr_pkg.sv ====
// Constants shared by the receive cell FIFO read port.
package rcfr_pkg;
	localparam int RCFR_AW = 8;
	localparam int RCFR_DEPTH = 256;
	localparam logic [8:0] RCFR_CELL_LEN = 9'h035;
	localparam logic [8:0] RCFR_THR_ZERO = 9'h000;
	localparam logic [8:0] RCFR_THR_FOUR = 9'h004;
	localparam logic [7:0] RCFR_CFG_OFF = 8'h00;
	localparam logic [7:0] RCFR_STAT_OFF = 8'h04;
	localparam int RCFR_CFG_THR4_BIT = 0;
	localparam int RCFR_CFG_POLLO_BIT = 1;
	localparam int RCFR_CFG_ODD_BIT = 2;
	localparam logic [2:0] RCFR_CFG_RST = 3'h0;
	localparam int RCFR_STAT_FULL_BIT = 9;
	localparam logic [1:0] RCFR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCFR_RESP_SLVERR = 2'h2;
endpackage : rcfr_pkg

// ==== design/rcfr_top.sv ====
// Receive cell FIFO: core-side write port, register slave and external read port.
// What this block does
// [R1] Strap high makes the byte bus a shared tristate bus governed by read enable.
// [R2] Strap high and read enable sampled high release byte, parity and first-byte outputs.
// [R3] Strap high and read enable sampled low drive byte, parity and first-byte outputs.
// [R4] Strap low keeps byte, parity and first-byte outputs driven at all times outside read-side reset.
// [R5] Read enable is sampled only on rising edges of the read clock.
// [R6] Byte, parity, first-byte and cell-present outputs change only on read clock edges.
// [R7] A full FIFO stalls the core-side writer, so the FIFO does not overflow.
// [R8] Read enable low with data stored pops exactly one byte onto the bus.
// [R9] Read enable high performs no read and leaves pointer and contents alone.
// [R10] The reader may pause with read enable high at any cycle, even mid-cell.
// [R11] With zero threshold, cell-present marks valid bytes; empty FIFO gives none.
// [R12] Cell-present drops at zero or four bytes left; polarity programmable, default high.
// [R13] First-byte output is high for the one read clock cycle after a cell's first octet is popped onto the bus.
// [R14] Parity output covers the current byte; odd or even chosen by register.
// [R15] Cell-present asserts only with a complete cell stored; between the threshold and a complete cell it only holds its level.
`timescale 1ns/1ps
module rcfr_top
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic cell_wr_valid,
	output logic cell_wr_ready,
	input wire logic [7:0] cell_wr_byte,
	input wire logic cell_wr_first,
	input wire logic rx_read_clock,
	input wire logic rx_read_enable_n,
	input wire logic bus_drive_mode_strap,
	output logic [7:0] rx_cell_byte,
	output logic rx_byte_parity,
	output logic rx_cell_first_byte,
	output logic rx_bus_oe,
	output logic rx_cell_present
);
	import rcfr_pkg::*;

	// Gray to binary conversion for pointers arriving from the other domain.
	function automatic logic [8:0] rcfr_g2b(input logic [8:0] g);
		logic [8:0] b;
		b[8] = g[8];
		for (int i = 7; i >= 0; i--)
			b[i] = b[i + 1] ^ g[i];
		return b;
	endfunction : rcfr_g2b

	logic [8:0] mem [RCFR_DEPTH];
	logic [8:0] wr_bin_reg;
	logic [8:0] wr_gray_reg;
	logic [8:0] rd_gray_s1_reg;
	logic [8:0] rd_gray_s2_reg;
	logic [8:0] rd_bin_core;
	logic [8:0] core_level;
	logic fifo_full;
	logic wr_fire;
	logic [2:0] cfg_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	// Read clock domain signals; the reset synchroniser powers up asserted so the read side starts in reset.
	logic rd_rst_s1_reg = 1'b0;
	logic rd_rst_n = 1'b0;
	logic [8:0] wr_gray_s1_reg;
	logic [8:0] wr_gray_s2_reg;
	logic [2:0] cfg_s1_reg;
	logic [2:0] cfg_s2_reg;
	logic strap_s1_reg;
	logic strap_s2_reg;
	logic [8:0] rd_bin_reg;
	logic [8:0] rd_gray_reg;
	logic [8:0] rd_level;
	logic [8:0] rd_level_next;
	logic [8:0] present_thr;
	logic rd_empty;
	logic rd_pop;
	logic present_reg;
	logic present_next;
	logic [8:0] head;

	// Core-side fill level; the read pointer is a synchronised gray copy.
	assign rd_bin_core = rcfr_g2b(rd_gray_s2_reg);
	assign core_level = wr_bin_reg - rd_bin_core;
	assign fifo_full = core_level[8];
	assign cell_wr_ready = ~fifo_full; // R7
	assign wr_fire = cell_wr_valid & ~fifo_full;

	// Write pointer and storage; a refused byte stalls the source instead of being lost.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			wr_bin_reg <= 9'h000;
			wr_gray_reg <= 9'h000;
		end
		else if (wr_fire)
		begin
			wr_bin_reg <= wr_bin_reg + 9'h001;
			wr_gray_reg <= (wr_bin_reg + 9'h001) ^ ((wr_bin_reg + 9'h001) >> 1);
		end
	end

	// The array needs no reset; only slots behind the write pointer are ever read.
	always_ff @(posedge core_clk)
	begin
		if (wr_fire)
			mem[wr_bin_reg[RCFR_AW-1:0]] <= {cell_wr_first, cell_wr_byte};
	end

	// Read pointer crossing into the core domain, two flops deep.
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rd_gray_s1_reg <= 9'h000;
			rd_gray_s2_reg <= 9'h000;
		end
		else
		begin
			rd_gray_s1_reg <= rd_gray_reg;
			rd_gray_s2_reg <= rd_gray_s1_reg;
		end
	end

	// Write address and data are taken in either order and held until both are here.
	assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RCFR_RESP_OKAY;
			cfg_reg <= RCFR_CFG_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_have_reg && w_have_reg)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg[7:2] == RCFR_CFG_OFF[7:2])
				begin
					s_axi_bresp <= RCFR_RESP_OKAY;
					if (w_strb_reg[0])
						cfg_reg <= w_data_reg[2:0];
				end
				else if (aw_addr_reg[7:2] == RCFR_STAT_OFF[7:2])
					s_axi_bresp <= RCFR_RESP_OKAY;
				else
					s_axi_bresp <= RCFR_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Register reads; status shows the live fill level and the full flag.
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RCFR_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RCFR_RESP_OKAY;
			if (s_axi_araddr[7:2] == RCFR_CFG_OFF[7:2])
				s_axi_rdata <= {29'h0000000, cfg_reg};
			else if (s_axi_araddr[7:2] == RCFR_STAT_OFF[7:2])
				s_axi_rdata <= {22'h00000, fifo_full, core_level};
			else
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= RCFR_RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Reset, write pointer, configuration and strap all reach the read side via two flops.
	// The configuration bits are independent and quasi-static, so a one-cycle skew between them is harmless.
	always_ff @(posedge rx_read_clock)
	begin
		rd_rst_s1_reg <= resetn;
		rd_rst_n <= rd_rst_s1_reg;
		wr_gray_s1_reg <= wr_gray_reg;
		wr_gray_s2_reg <= wr_gray_s1_reg;
		cfg_s1_reg <= cfg_reg;
		cfg_s2_reg <= cfg_s1_reg;
		strap_s1_reg <= bus_drive_mode_strap;
		strap_s2_reg <= strap_s1_reg;
	end

	// Read enable is a same-domain input and is used as sampled at the read clock edge.
	assign rd_level = rcfr_g2b(wr_gray_s2_reg) - rd_bin_reg;
	assign rd_empty = (rd_level == 9'h000);
	assign rd_pop = ~rx_read_enable_n & ~rd_empty; // R5 R8 R10
	assign rd_level_next = rd_level - {8'h00, rd_pop};
	assign present_thr = cfg_s2_reg[RCFR_CFG_THR4_BIT] ? RCFR_THR_FOUR : RCFR_THR_ZERO; // R12
	assign head = mem[rd_bin_reg[RCFR_AW-1:0]];

	// Pop pointer moves only on a taken read; a stall leaves it untouched.
	always_ff @(posedge rx_read_clock)
	begin
		if (!rd_rst_n)
		begin
			rd_bin_reg <= 9'h000;
			rd_gray_reg <= 9'h000;
		end
		else if (rd_pop) // R8 R9
		begin
			rd_bin_reg <= rd_bin_reg + 9'h001;
			rd_gray_reg <= (rd_bin_reg + 9'h001) ^ ((rd_bin_reg + 9'h001) >> 1);
		end
	end

	// Bus outputs; stale data stays on an empty read, so the reader relies on cell-present.
	always_ff @(posedge rx_read_clock)
	begin
		if (!rd_rst_n)
		begin
			rx_cell_byte <= 8'h00;
			rx_cell_first_byte <= 1'b0;
			rx_byte_parity <= 1'b0;
		end
		else if (rd_pop) // R6
		begin
			rx_cell_byte <= head[7:0];
			rx_cell_first_byte <= head[8]; // R13
			rx_byte_parity <= ^head[7:0] ^ cfg_s2_reg[RCFR_CFG_ODD_BIT]; // R14
		end
		else
			rx_cell_first_byte <= 1'b0; // R13
	end

	// Drive control is registered from the read enable seen at the same edge.
	always_ff @(posedge rx_read_clock)
	begin
		if (!rd_rst_n)
			rx_bus_oe <= 1'b0;
		else if (strap_s2_reg) // R1
			rx_bus_oe <= ~rx_read_enable_n; // R2 R3
		else
			rx_bus_oe <= 1'b1; // R4
	end

	// Cell-present rises on a whole cell and falls at the threshold, giving hysteresis.
	always_comb
	begin
		present_next = present_reg;
		if (rd_level_next >= RCFR_CELL_LEN)
			present_next = 1'b1; // R15
		else if (rd_level_next <= present_thr)
			present_next = 1'b0; // R11 R12
	end

	always_ff @(posedge rx_read_clock)
	begin
		if (!rd_rst_n)
		begin
			present_reg <= 1'b0;
			rx_cell_present <= 1'b0;
		end
		else
		begin
			present_reg <= present_next;
			rx_cell_present <= present_next ^ cfg_s2_reg[RCFR_CFG_POLLO_BIT]; // R6 R12
		end
	end

	// Checks on the read side, plus the core-side full stall.
	sequence s_rd_pop;
		!rx_read_enable_n && !rd_empty;
	endsequence
	sequence s_rd_idle;
		rx_read_enable_n;
	endsequence

	chk_tristate_release: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R2
		strap_s2_reg && rx_read_enable_n |=> !rx_bus_oe)
		else $error("Bus still driven after read enable high in tristate mode.");
	chk_tristate_drive: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R3
		strap_s2_reg && !rx_read_enable_n |=> rx_bus_oe)
		else $error("Bus not driven after read enable low in tristate mode.");
	chk_always_driven: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R4
		!strap_s2_reg |=> rx_bus_oe)
		else $error("Bus released while strap selects always driven.");
	chk_pop_one: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R8
		s_rd_pop |=> rd_bin_reg == $past(rd_bin_reg) + 9'h001 && rx_cell_byte == $past(head[7:0]))
		else $error("Read did not pop exactly one byte onto the bus.");
	chk_idle_hold: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R9
		s_rd_idle |=> $stable(rd_bin_reg) && $stable(rx_cell_byte))
		else $error("Pointer or data moved without a read.");
	chk_first_marker: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R13
		rx_cell_first_byte |-> $past(rd_pop) && $past(head[8]))
		else $error("First-byte marker without a first octet on the bus.");
	chk_parity_match: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R14
		s_rd_pop |=> rx_byte_parity == (^rx_cell_byte ^ $past(cfg_s2_reg[RCFR_CFG_ODD_BIT])))
		else $error("Parity output does not match the byte on the bus.");
	chk_empty_absent: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R11
		rd_level_next == 9'h000 |=> !present_reg)
		else $error("Cell-present held with an empty FIFO.");
	chk_present_cause: assert property (@(posedge rx_read_clock) disable iff (!rd_rst_n) // R15
		$rose(present_reg) |-> $past(rd_level_next) >= RCFR_CELL_LEN)
		else $error("Cell-present rose without a whole cell stored.");
	chk_full_stall: assert property (@(posedge core_clk) disable iff (!resetn) // R7
		fifo_full |-> !cell_wr_ready ##1 $stable(wr_bin_reg))
		else $error("Write taken while FIFO full.");
endmodule : rcfr_top

// ==== verification/rcfr_reader_model.sv ====
// Behavioural reader that stands on the far side of the receive byte bus.
`timescale 1ns/1ps
module rcfr_reader_model
(
	input wire logic rx_read_clock,
	input wire logic pause,
	input wire logic [7:0] rx_cell_byte,
	input wire logic rx_byte_parity,
	input wire logic rx_cell_first_byte,
	input wire logic rx_bus_oe,
	output logic rx_read_enable_n
);
	logic [9:0] last_reg = 10'h000;
	logic [9:0] bus;
	logic [9:0] cap_q[$];
	initial rx_read_enable_n = 1'b1;
	// A released bus shows the inverse of its last level, so a stale value never passes for data.
	assign bus = rx_bus_oe ? {rx_cell_first_byte, rx_byte_parity, rx_cell_byte} : ~last_reg;
	// Remember what was last driven.
	always @(posedge rx_read_clock) if (rx_bus_oe) last_reg <= bus;
	// Reads n bytes with random pauses, also mid-cell; a byte is captured one edge after its pop.
	task read_n(input int n);
		int cnt;
		logic took;
		cnt = 0;
		took = 1'b0;
		while (cnt < n || took)
		begin
			@(posedge rx_read_clock);
			if (took) cap_q.push_back(bus);
			took = !rx_read_enable_n;
			if (took) cnt++;
			rx_read_enable_n <= !(cnt < n && !pause);
		end
	endtask : read_n
endmodule : rcfr_reader_model

// ==== verification/testbench.sv ====
// Self-checking bench for the receive cell FIFO read port.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("ERROR %0t: %0h != %0h", $time, g, e); end end
module testbench;
	import rcfr_pkg::*;
	logic core_clk = 1'b0;
	logic rx_read_clock = 1'b0;
	logic resetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, cell_wr_valid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, bus_drive_mode_strap = 1'b1, cell_wr_first = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cell_wr_byte = 8'h00, lfsr = 8'h25, pz = 8'h25;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cell_wr_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] rx_cell_byte, last_b;
	logic rx_byte_parity, rx_cell_first_byte, rx_bus_oe, rx_cell_present, rx_read_enable_n;
	logic odd = 1'b0, pol = 1'b0, oe_chk = 1'b0, en_low = 1'b0;
	logic [8:0] exp_q[$];
	int errors = 0;
	int n_tests = 0;
	rcfr_top i_rcfr_top (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cell_wr_valid,
		.cell_wr_ready, .cell_wr_byte, .cell_wr_first, .rx_read_clock, .rx_read_enable_n, .bus_drive_mode_strap,
		.rx_cell_byte, .rx_byte_parity, .rx_cell_first_byte, .rx_bus_oe, .rx_cell_present);
	rcfr_reader_model i_rcfr_reader_model (.rx_read_clock, .pause(pz[0] & pz[1]), .rx_cell_byte, .rx_byte_parity,
		.rx_cell_first_byte, .rx_bus_oe, .rx_read_enable_n);
	// Clocks: the read clock has its own period and an offset phase.
	initial forever #2.5 core_clk = ~core_clk;
	initial
	begin
		#7;
		forever #24 rx_read_clock = ~rx_read_clock;
	end
	// Pause pattern for the reader.
	always @(posedge core_clk) pz <= lfsr_f(pz);
	// Output enable must follow the read enable sampled at the previous edge in bus-sharing mode.
	always @(posedge rx_read_clock)
	begin
		if (oe_chk) `CHK(rx_bus_oe, bus_drive_mode_strap ? en_low : 1'b1);
		en_low = !rx_read_enable_n;
	end
	function automatic logic [7:0] lfsr_f(input logic [7:0] s);
		return s[0] ? ((s >> 1) ^ 8'hB8) : (s >> 1);
	endfunction : lfsr_f
	function automatic logic [9:0] exp_cap(input logic [8:0] e);
		return {e[8], ^e[7:0] ^ odd, e[7:0]};
	endfunction : exp_cap
	task summarize;
		if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	// Lets crossings settle; several read clocks pass.
	task settle;
		repeat (60) @(posedge core_clk);
	endtask : settle
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		`CHK(s_axi_bresp, r);
		// Release the response handshake and let one edge pass before the next request.
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		`CHK(s_axi_rdata & m, e);
		`CHK(s_axi_rresp, r);
		// Release the read handshake and let one edge pass before the next request.
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask : axi_rd
	// Pushes n random bytes; off is the position within the cell of the first one.
	task push_n(input int n, input int off);
		for (int i = 0; i < n; i++)
		begin
			lfsr = lfsr_f(lfsr);
			cell_wr_valid <= 1'b1;
			cell_wr_byte <= lfsr;
			cell_wr_first <= ((i + off) % 53) == 0;
			do @(posedge core_clk); while (cell_wr_ready !== 1'b1);
			exp_q.push_back({((i + off) % 53) == 0, lfsr});
		end
		cell_wr_valid <= 1'b0;
	endtask : push_n
	// Compares what the reader captured with what was written, in order.
	task check_caps;
		logic [9:0] c;
		logic [8:0] e;
		`CHK(i_rcfr_reader_model.cap_q.size(), exp_q.size());
		while (exp_q.size() > 0 && i_rcfr_reader_model.cap_q.size() > 0)
		begin
			e = exp_q.pop_front();
			c = i_rcfr_reader_model.cap_q.pop_front();
			`CHK(c, exp_cap(e));
			last_b = e[7:0];
		end
		exp_q.delete();
		i_rcfr_reader_model.cap_q.delete();
	endtask : check_caps
	// Watchdog against a hang.
	initial
	begin
		repeat (40000) @(posedge core_clk);
		errors++;
		summarize;
	end
	// Main sequence.
	initial
	begin
		repeat (12) @(posedge rx_read_clock);
		@(posedge core_clk);
		resetn <= 1'b1;
		settle;
		axi_rd(RCFR_CFG_OFF, 32'h7, {29'h0, RCFR_CFG_RST}, RCFR_RESP_OKAY);
		`CHK(rx_cell_present, 1'b0);
		axi_rd(8'h08, 32'h0, 32'h0, RCFR_RESP_SLVERR);
		axi_wr(8'h08, 32'h7, RCFR_RESP_SLVERR);
		axi_wr(RCFR_STAT_OFF, 32'h0, RCFR_RESP_OKAY);
		// A write without the low byte lane must leave the settings alone.
		s_axi_wstrb <= 4'hE;
		axi_wr(RCFR_CFG_OFF, 32'h7, RCFR_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(RCFR_CFG_OFF, 32'h7, {29'h0, RCFR_CFG_RST}, RCFR_RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			oe_chk = 1'b0;
			bus_drive_mode_strap <= k[0];
			odd = k[1];
			pol = k[0] ^ k[1];
			settle;
			oe_chk = 1'b1;
			axi_wr(RCFR_CFG_OFF, {29'h0, odd, pol, 1'b0}, RCFR_RESP_OKAY);
			push_n(52, 0);
			settle;
			`CHK(rx_cell_present, pol);
			push_n(1, 52);
			settle;
			`CHK(rx_cell_present, !pol);
			axi_rd(RCFR_STAT_OFF, 32'h3FF, 32'h035, RCFR_RESP_OKAY);
			i_rcfr_reader_model.read_n(53);
			settle;
			`CHK(rx_cell_present, pol);
			check_caps;
		end
		odd = 1'b0;
		axi_wr(RCFR_CFG_OFF, 32'h1, RCFR_RESP_OKAY);
		push_n(53, 0);
		settle;
		i_rcfr_reader_model.read_n(48);
		settle;
		`CHK(rx_cell_present, 1'b1);
		i_rcfr_reader_model.read_n(1);
		settle;
		`CHK(rx_cell_present, 1'b0);
		axi_rd(RCFR_STAT_OFF, 32'h3FF, 32'h004, RCFR_RESP_OKAY);
		axi_wr(RCFR_CFG_OFF, 32'h0, RCFR_RESP_OKAY);
		i_rcfr_reader_model.read_n(4);
		check_caps;
		exp_q.push_back({1'b0, last_b});
		i_rcfr_reader_model.read_n(1);
		check_caps;
		axi_rd(RCFR_STAT_OFF, 32'h3FF, 32'h000, RCFR_RESP_OKAY);
		push_n(256, 0);
		repeat (2) @(posedge core_clk);
		`CHK(cell_wr_ready, 1'b0);
		settle;
		axi_rd(RCFR_STAT_OFF, 32'h3FF, 32'h300, RCFR_RESP_OKAY);
		`CHK(rx_cell_present, 1'b1);
		i_rcfr_reader_model.read_n(256);
		check_caps;
		summarize;
	end
endmodule : testbench
